// *** logic/ipab_defines.vh ***
/*
 indexed port access constants: port offsets, pointer layout, reset values.
 assumes inclusion by bare name from the design files.
*/
`ifndef IPAB_DEFINES_VH
`define IPAB_DEFINES_VH
`define IPAB_PORT_INDEX 3'h5
`define IPAB_PORT_DATA 3'h6
`define IPAB_BUSY_BIT 7
`define IPAB_PTR_MSB 6
`define IPAB_PTR_RST 7'h00
`define IPAB_ADDR_CONFIG 7'h40
`define IPAB_ADDR_ISTAT1 7'h41
`define IPAB_ADDR_ISTAT2 7'h42
`define IPAB_ADDR_SMIM1 7'h43
`define IPAB_ADDR_SMIM2 7'h44
`define IPAB_ADDR_NMIM1 7'h45
`define IPAB_ADDR_NMIM2 7'h46
`define IPAB_CONFIG_RST 8'h08
`define IPAB_ISTAT_RST 8'h00
`endif

// *** logic/ipab_sync.v ***
/*
 three-stage synchroniser for one pin level; output changes when stages two
 and three agree. assumes mclk domain, synchronous active low reset.
*/
`timescale 1ns/100ps
module ipab_sync
(
   mclk,
   rst_n,
   din,
   dout
);
   input wire mclk;
   input wire rst_n;
   input wire din;
   output reg dout;
   reg s1_r;
   reg s2_r;
   reg s3_r;
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         s1_r <= 1'b0;
         s2_r <= 1'b0;
         s3_r <= 1'b0;
         dout <= 1'b0;
      end
      else
      begin
         s1_r <= din;
         s2_r <= s1_r;
         s3_r <= s2_r;
         if (s2_r == s3_r)
            dout <= s3_r;
      end
   end
endmodule // ipab_sync

// *** logic/ipab_port.v ***
/*
 indexed host port front end: index/busy register at offset 5, data port at
 offset 6, pointer selecting internal registers, busy arbitration with the
 serial bus engine. assumes the isa strobes and serial busy come from pins;
 register contents outside configuration and interrupt status live elsewhere
 and are reached through the ext_* pins.
*/
// What this block does
// - seven-bit pointer in bits 6..0 of index register, readable and writable
// - bit 7 of index register is read-only busy flag
// - busy sets on index write or while serial transaction runs
// - index-set busy clears on next data access; serial busy ends with transaction
// - data access at interrupt status 1 advances pointer to status 2
// - data port serves register and ram reads using the pointer
`timescale 1ns/100ps
`include "ipab_defines.vh"
module ipab_port
(
   mclk,
   rst_n,
   cs_n,
   ior_n,
   iow_n,
   addr,
   data_in,
   data_out,
   data_oe,
   sbus_busy,
   ext_addr,
   ext_wdata,
   ext_wr,
   ext_rd,
   ext_rdata,
   istat1_set,
   istat2_set,
   config_out
);
   input wire mclk;
   input wire rst_n;
   input wire cs_n;
   input wire ior_n;
   input wire iow_n;
   input wire [2:0] addr;
   input wire [7:0] data_in;
   output reg [7:0] data_out;
   output wire data_oe;
   input wire sbus_busy;
   output wire [6:0] ext_addr;
   output reg [7:0] ext_wdata;
   output reg ext_wr;
   output reg ext_rd;
   input wire [7:0] ext_rdata;
   input wire [7:0] istat1_set;
   input wire [7:0] istat2_set;
   output wire [7:0] config_out;

   wire cs_s;
   wire rd_s;
   wire wr_s;
   wire sb_s;
   // bits 10..8 carry the port offset, 7..0 the write data
   wire [10:0] bus_raw;
   wire [10:0] bus_s;
   wire [2:0] addr_s;
   wire [7:0] din_s;
   reg rd_d_r;
   reg wr_d_r;
   reg [6:0] ptr_r;
   reg host_busy_r;
   reg [7:0] config_r;
   reg [7:0] istat1_r;
   reg [7:0] istat2_r;
   // next values, all produced by the single decode process below
   reg [6:0] ptr_nxt;
   reg host_busy_nxt;
   reg [7:0] config_nxt;
   reg [7:0] istat1_nxt;
   reg [7:0] istat2_nxt;
   reg [7:0] rdata_nxt;
   reg [7:0] wdata_nxt;
   reg ext_wr_nxt;
   reg ext_rd_nxt;
   wire rd_pulse;
   wire wr_pulse;
   wire idx_sel;
   wire dat_sel;
   wire dat_acc;
   wire int_loc;
   wire busy;
   genvar gi;

   // strobes are asynchronous pins; synchronise before edge detection
   ipab_sync u_cs (.mclk(mclk), .rst_n(rst_n), .din(~cs_n), .dout(cs_s));
   ipab_sync u_rd (.mclk(mclk), .rst_n(rst_n), .din(~ior_n), .dout(rd_s));
   ipab_sync u_wr (.mclk(mclk), .rst_n(rst_n), .din(~iow_n), .dout(wr_s));
   ipab_sync u_sb (.mclk(mclk), .rst_n(rst_n), .din(sbus_busy), .dout(sb_s));
   // offset and data are pins as well; the same filter on every bit keeps them
   // in step with the strobes, so they are settled when the synced edge acts
   assign bus_raw = {addr, data_in};
   generate
      for (gi = 0; gi < 11; gi = gi + 1)
      begin : g_bus
         ipab_sync u_ipab_sync (.mclk(mclk), .rst_n(rst_n), .din(bus_raw[gi]),
            .dout(bus_s[gi]));
      end
   endgenerate
   assign addr_s = bus_s[10:8];
   assign din_s = bus_s[7:0];

   // limitation: offset and data must be stable across the whole strobe
   assign rd_pulse = rd_s & ~rd_d_r & cs_s;
   assign wr_pulse = wr_s & ~wr_d_r & cs_s;
   assign idx_sel = (addr_s == `IPAB_PORT_INDEX);
   assign dat_sel = (addr_s == `IPAB_PORT_DATA);
   assign dat_acc = dat_sel & (rd_pulse | wr_pulse);
   // config and the status pair live here; ext_wr stays low for writes to them, though ext_wdata still takes the data
   assign int_loc = (ptr_r == `IPAB_ADDR_CONFIG) | (ptr_r == `IPAB_ADDR_ISTAT1) |
      (ptr_r == `IPAB_ADDR_ISTAT2);
   assign busy = host_busy_r | sb_s;
   assign data_oe = cs_s & rd_s & (idx_sel | dat_sel);
   assign ext_addr = ptr_r;
   assign config_out = config_r;

   // decode of one access per cycle; defaults hold every register but the status pair (ORs in events) and ext_wr/ext_rd (clear)
   always @*
   begin
      ptr_nxt = ptr_r;
      host_busy_nxt = host_busy_r;
      config_nxt = config_r;
      rdata_nxt = data_out;
      wdata_nxt = ext_wdata;
      ext_wr_nxt = 1'b0;
      ext_rd_nxt = 1'b0;
      // status clears on read, but a new event in the same cycle wins
      istat1_nxt = istat1_r | istat1_set;
      istat2_nxt = istat2_r | istat2_set;
      if (idx_sel & wr_pulse)
      begin
         ptr_nxt = din_s[`IPAB_PTR_MSB:0];
         host_busy_nxt = 1'b1;
      end
      else if (dat_acc)
      begin
         host_busy_nxt = 1'b0;
         // only status 1 advances, to status 2, so repeated accesses elsewhere hit one register
         if (ptr_r == `IPAB_ADDR_ISTAT1)
            ptr_nxt = `IPAB_ADDR_ISTAT2;
         else
            ptr_nxt = ptr_r;
      end
      if (idx_sel & rd_pulse)
         rdata_nxt = {busy, ptr_r};
      else if (dat_sel & rd_pulse)
      begin
         ext_rd_nxt = 1'b1;
         case (ptr_r)
            `IPAB_ADDR_CONFIG: rdata_nxt = config_r;
            `IPAB_ADDR_ISTAT1:
            begin
               rdata_nxt = istat1_r;
               istat1_nxt = istat1_set;
            end
            `IPAB_ADDR_ISTAT2:
            begin
               rdata_nxt = istat2_r;
               istat2_nxt = istat2_set;
            end
            default: rdata_nxt = ext_rdata;
         endcase
      end
      if (dat_sel & wr_pulse)
      begin
         wdata_nxt = din_s;
         ext_wr_nxt = ~int_loc;
         if (ptr_r == `IPAB_ADDR_CONFIG)
            config_nxt = din_s;
      end
   end

   // control state: edge detectors, pointer, busy and the one-cycle strobes
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         rd_d_r <= 1'b0;
         wr_d_r <= 1'b0;
         ptr_r <= `IPAB_PTR_RST;
         host_busy_r <= 1'b0;
         ext_wr <= 1'b0;
         ext_rd <= 1'b0;
      end
      else
      begin
         rd_d_r <= rd_s;
         wr_d_r <= wr_s;
         ptr_r <= ptr_nxt;
         host_busy_r <= host_busy_nxt;
         ext_wr <= ext_wr_nxt;
         ext_rd <= ext_rd_nxt;
      end
   end

   // data holding registers; kept apart so the control path reads on its own
   always @(posedge mclk)
   begin
      if (!rst_n)
      begin
         config_r <= `IPAB_CONFIG_RST;
         istat1_r <= `IPAB_ISTAT_RST;
         istat2_r <= `IPAB_ISTAT_RST;
         data_out <= 8'h00;
         ext_wdata <= 8'h00;
      end
      else
      begin
         config_r <= config_nxt;
         istat1_r <= istat1_nxt;
         istat2_r <= istat2_nxt;
         data_out <= rdata_nxt;
         ext_wdata <= wdata_nxt;
      end
   end
endmodule // ipab_port

// *** verification/ipab_chk.sv ***
/* pin checks for ipab_port
 bound onto ipab_port; one mclk domain */
`timescale 1ns/100ps
module ipab_chk
(
   input wire mclk,
   input wire rst_n,
   input wire ior_n,
   input wire iow_n,
   input wire data_oe,
   input wire [6:0] ext_addr,
   input wire ext_wr,
   input wire ext_rd
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rst_n);
   sequence s_ri; ior_n [*7]; endsequence
   sequence s_wi; iow_n [*7]; endsequence
   property p_rp; ext_rd |=> !ext_rd; endproperty
   a_rp: assert property (p_rp) else $error("rd pulse");
   property p_wp; ext_wr |=> !ext_wr; endproperty
   a_wp: assert property (p_wp) else $error("wr pulse");
   property p_rq; s_ri |-> !ext_rd && !data_oe; endproperty
   a_rq: assert property (p_rq) else $error("rd idle");
   property p_wq; s_wi |-> !ext_wr; endproperty
   a_wq: assert property (p_wq) else $error("wr idle");
   property p_oe; ext_rd |-> data_oe; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_inc; ext_rd && $past(ext_addr) == 7'h41 |-> ext_addr == 7'h42; endproperty
   a_inc: assert property (p_inc) else $error("advance");
   property p_hold; ext_rd && $past(ext_addr) != 7'h41 |-> $stable(ext_addr); endproperty
   a_hold: assert property (p_hold) else $error("hold");
   property p_q; (ior_n && iow_n) [*7] |-> $stable(ext_addr); endproperty
   a_q: assert property (p_q) else $error("quiet");
endmodule // ipab_chk
bind ipab_port ipab_chk u_ipab_chk (.mclk(mclk), .rst_n(rst_n), .ior_n(ior_n),
   .iow_n(iow_n), .data_oe(data_oe), .ext_addr(ext_addr), .ext_wr(ext_wr), .ext_rd(ext_rd));

// *** verification/ipab_far.sv ***
/* far side: storage behind ext_* and the serial master's busy line
 assumes one-cycle ext_wr/ext_rd pulses */
`timescale 1ns/100ps
module ipab_far
(
   input wire mclk,
   input wire [6:0] ext_addr,
   input wire [7:0] ext_wdata,
   input wire ext_wr,
   input wire ext_rd,
   output wire [7:0] ext_rdata,
   output reg sbus_busy
);
   reg [7:0] mem_r [0:127];
   initial sbus_busy = 1'h0;
   // read port follows the pointer; the design takes it on the edge that raises ext_rd
   assign ext_rdata = mem_r[ext_addr];
   always @(posedge mclk)
      if (ext_wr)
         mem_r[ext_addr] <= ext_wdata;
   // only called between host cycles
   task sbus(input b);
      #1 sbus_busy = b;
   endtask
endmodule // ipab_far

// *** verification/ipab_port_tb_top.sv ***
/* bench for ipab_port with ipab_far behind it
 assumes ipab_chk is bound by its own file */
`timescale 1ns/100ps
module ipab_port_tb_top;
   reg mclk = 1'h0;
   reg rst_n = 1'h0;
   reg cs_n = 1'h1;
   reg ior_n = 1'h1;
   reg iow_n = 1'h1;
   reg [2:0] addr = 3'h0;
   reg [7:0] din = 8'h00;
   reg [7:0] iset1 = 8'h00;
   reg [7:0] rd;
   wire [7:0] dout, erdata, ewdata, cfg;
   wire [6:0] eaddr;
   wire ewr, erd, sbusy, doe;
   integer error_cnt = 0;
   integer samples_checked = 0;
   ipab_port u_ipab_port (.mclk(mclk), .rst_n(rst_n), .cs_n(cs_n), .ior_n(ior_n),
      .iow_n(iow_n), .addr(addr), .data_in(din), .data_out(dout), .data_oe(doe),
      .sbus_busy(sbusy), .ext_addr(eaddr), .ext_wdata(ewdata), .ext_wr(ewr), .ext_rd(erd),
      .ext_rdata(erdata), .istat1_set(iset1), .istat2_set(8'h00), .config_out(cfg));
   ipab_far u_ipab_far (.mclk(mclk), .ext_addr(eaddr), .ext_wdata(ewdata),
      .ext_wr(ewr), .ext_rd(erd), .ext_rdata(erdata), .sbus_busy(sbusy));
   initial forever #10 mclk = ~mclk;
   task check(input string nm, input [7:0] got, input [7:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp)
      begin
         error_cnt = error_cnt + 1;
         $display("CHECK FAILED %0s exp %h got %h", nm, exp, got);
      end
   endtask
   // strobe held 8 cycles: synchroniser needs about 5 before data_out lands
   task cyc(input w, input [2:0] a, input [7:0] d);
      @(posedge mclk) #1;
      cs_n = 1'h0;
      addr = a;
      din = d;
      ior_n = w;
      iow_n = !w;
      repeat (8) @(posedge mclk);
      rd = dout;
      check("data oe", {7'h00, doe}, {7'h00, !w});
      #1 ior_n = 1'h1;
      iow_n = 1'h1;
      cs_n = 1'h1;
      repeat (6) @(posedge mclk);
      check("oe idle", {7'h00, doe}, 8'h00);
   endtask
   // drivers wait for busy to read zero before an index-then-data sequence
   task poll_idle;
      integer n;
      begin
         n = 0;
         cyc(0, 3'h5, 8'h00);
         while (rd[7] !== 1'b0 && n < 16)
         begin
            n = n + 1;
            cyc(0, 3'h5, 8'h00);
         end
         if (rd[7] !== 1'b0)
         begin
            check("busy poll", rd, {1'b0, rd[6:0]});
            results;
         end
      end
   endtask
   task t_reset;
      cyc(0, 3'h5, 8'h00);
      check("index", rd, 8'h00);
      cyc(1, 3'h5, 8'h40);
      cyc(0, 3'h6, 8'h00);
      check("config", rd, 8'h08);
      cyc(1, 3'h6, 8'h3C);
      check("config out", cfg, 8'h3C);
   endtask
   task t_busy;
      poll_idle;
      cyc(1, 3'h5, 8'h95);
      cyc(0, 3'h5, 8'h00);
      check("busy set", rd, 8'h95);
      cyc(1, 3'h6, 8'hA5);
      cyc(0, 3'h5, 8'h00);
      check("busy clr", rd, 8'h15);
      cyc(0, 3'h6, 8'h00);
      check("same reg", rd, 8'hA5);
   endtask
   task t_inc;
      cyc(1, 3'h5, 8'h41);
      @(posedge mclk) #1 iset1 = 8'h05;
      @(posedge mclk) #1 iset1 = 8'h00;
      cyc(0, 3'h6, 8'h00);
      check("status", rd, 8'h05);
      cyc(0, 3'h5, 8'h00);
      check("advance rd", rd, 8'h42);
      cyc(1, 3'h5, 8'h41);
      cyc(0, 3'h6, 8'h00);
      check("status clr", rd, 8'h00);
      cyc(1, 3'h5, 8'h41);
      cyc(1, 3'h6, 8'h00);
      cyc(0, 3'h5, 8'h00);
      check("advance wr", rd, 8'h42);
   endtask
   task t_sbus;
      u_ipab_far.sbus(1'h1);
      cyc(0, 3'h5, 8'h00);
      check("sbus busy", rd, 8'hC2);
      u_ipab_far.sbus(1'h0);
      poll_idle;
      check("sbus done", rd, 8'h42);
   endtask
   task results;
      $display("errors %0d checks %0d", error_cnt, samples_checked);
      if (error_cnt == 0 && samples_checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial
   begin
      repeat (20) @(posedge mclk);
      #1 rst_n = 1'h1;
      t_reset;
      t_busy;
      t_inc;
      t_sbus;
      results;
   end
endmodule // ipab_port_tb_top
